// [shared/rstpc_pkg.sv]
// Constants for the reset output and pin state control block.
// Assumes one processor clock at 200 MHz and a synchronous active-high core reset.
//
// Functional notes
// - Float test mode floats all pins except oscillator drive.
// - Float low address/data bits during hold acknowledge.
// - Float low address/data bits while clear held low.
// - Reset output high, clock synchronous, follows clear length.
// - Reset output drops two clocks after clear released.
// - Reset output driven low during bus hold.
// - Reset looped to busy pin gives enhanced mode.
// - Enhanced needs busy high, then low four clocks later.
// - Fetch starts about six and half clocks after release.
// - Both selects low at release enters float test mode.
package rstpc_pkg;

  // ****************************************
  // Widths and counts
  // ****************************************
  localparam int unsigned AD_LOW_W = 8;
  localparam int unsigned PIN_W = 16;
  localparam logic [2:0] RELEASE_CYCLES = 3'h2;
  localparam logic [2:0] BUSY_SAMPLE_CYCLES = 3'h4;
  localparam logic [2:0] FETCH_CYCLES = 3'h6;
  localparam logic [2:0] CNT_RESET = 3'h0;
  localparam int unsigned SYNC_N = 5;
  localparam logic [4:0] SYNC_IDLE = 5'h0E;

endpackage : rstpc_pkg

// [core/rstpc_ctrl.sv]
// Reset output generation, mode strapping and pin float control.
// Assumes the clear input and strap pins are asynchronous to i_ref_clk.
// Every output is registered; the core reset is synchronous.
`timescale 1ns/100ps
module rstpc_ctrl (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_external_clear_input_n,
  input wire logic i_wait_test_busy,
  input wire logic i_upper_memory_select_n,
  input wire logic i_lower_memory_select_n,
  input wire logic i_hold_ack,
  input wire logic [rstpc_pkg::PIN_W-1:0] i_pin_drive_req,
  output logic o_reset_out,
  output logic o_reset_out_oe,
  output logic o_muxed_addr_data_low_bits_oe,
  output logic [rstpc_pkg::PIN_W-1:0] o_pin_oe,
  output logic o_oscillator_drive_pin_oe,
  output logic o_pin_float_test_mode,
  output logic o_enhanced_mode,
  output logic o_fetch_start
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  // The clear input and every strap cross into i_ref_clk through two flops.
  // Bit order: clear, busy, upper select, lower select, hold acknowledge.
  wire logic [rstpc_pkg::SYNC_N-1:0] async_in;
  wire logic [rstpc_pkg::SYNC_N-1:0] sync_bits;
  logic clr_prev_q;

  assign async_in[0] = i_external_clear_input_n;
  assign async_in[1] = i_wait_test_busy;
  assign async_in[2] = i_upper_memory_select_n;
  assign async_in[3] = i_lower_memory_select_n;
  assign async_in[4] = i_hold_ack;

  genvar sync_idx;
  generate
    for (sync_idx = 0; sync_idx < rstpc_pkg::SYNC_N; sync_idx++) begin : g_sync
      logic meta_q;
      logic stable_q;

      always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
          meta_q <= rstpc_pkg::SYNC_IDLE[sync_idx];
          stable_q <= rstpc_pkg::SYNC_IDLE[sync_idx];
        end else begin
          meta_q <= async_in[sync_idx];
          stable_q <= meta_q;
        end
      end

      assign sync_bits[sync_idx] = stable_q;
    end
  endgenerate

  wire logic clr_s = sync_bits[0];
  wire logic busy_s = sync_bits[1];
  wire logic upper_sel_n_s = sync_bits[2];
  wire logic lower_sel_n_s = sync_bits[3];
  wire logic hold = sync_bits[4];
  wire logic clr_low = ~clr_s;
  wire logic clr_rise = clr_s & ~clr_prev_q;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      clr_prev_q <= 1'b0;
    end else begin
      clr_prev_q <= clr_s;
    end
  end

  // ****************************************
  // Sequencer after clear release
  // ****************************************
  typedef enum logic [1:0] {ST_CLEAR, ST_RELEASE, ST_RUN} rstpc_state_e;
  rstpc_state_e state_q;
  rstpc_state_e state_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic busy_at_rise_q;
  logic enhanced_q;
  logic float_q;
  logic fetch_q;
  logic float_pending_q;

  wire logic release_done = (cnt_q == rstpc_pkg::RELEASE_CYCLES - 3'h1);
  // Busy is read the release time past the nominal point, so that a reset
  // output looped back to busy has passed the busy synchroniser by then.
  wire logic busy_sample = (state_q != ST_CLEAR) &&
    (cnt_q == rstpc_pkg::BUSY_SAMPLE_CYCLES + rstpc_pkg::RELEASE_CYCLES - 3'h1);
  wire logic fetch_hit = (state_q == ST_RUN) && (cnt_q == rstpc_pkg::FETCH_CYCLES - 3'h1);
  wire logic straps_low = ~upper_sel_n_s & ~lower_sel_n_s;
  wire logic float_arm = (state_q == ST_RELEASE) && (cnt_q == rstpc_pkg::CNT_RESET);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_CLEAR: begin
        cnt_d = rstpc_pkg::CNT_RESET;
        if (clr_rise) begin
          state_d = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        cnt_d = cnt_q + 3'h1;
        if (release_done) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (cnt_q != rstpc_pkg::FETCH_CYCLES) begin
          cnt_d = cnt_q + 3'h1;
        end
      end
      default: begin
        state_d = ST_CLEAR;
      end
    endcase
    if (clr_low) begin
      state_d = ST_CLEAR;
      cnt_d = rstpc_pkg::CNT_RESET;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_q <= ST_CLEAR;
      cnt_q <= rstpc_pkg::CNT_RESET;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      fetch_q <= 1'b0;
    end else begin
      fetch_q <= fetch_hit;
    end
  end

  // Straps are captured at the detected rise; a new clear drops the float strap only, the busy capture keeps its value.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      busy_at_rise_q <= 1'b0;
      float_pending_q <= 1'b0;
    end else if (clr_low) begin
      float_pending_q <= 1'b0;
    end else if (clr_rise) begin
      busy_at_rise_q <= busy_s;
      float_pending_q <= straps_low;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      float_q <= 1'b0;
    end else if (clr_low) begin
      float_q <= 1'b0;
    end else if (float_arm) begin
      float_q <= float_pending_q & straps_low;
    end
  end

  // A clear in the sample cycle wins, so compatible mode is kept then.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      enhanced_q <= 1'b0;
    end else if (clr_low) begin
      enhanced_q <= 1'b0;
    end else if (busy_sample) begin
      enhanced_q <= busy_at_rise_q & ~busy_s;
    end
  end

  // ****************************************
  // Pin output enables
  // ****************************************
  wire logic reset_active = (state_q != ST_RUN);
  wire logic reset_drive = reset_active & ~hold;
  wire logic ad_oe_d = ~float_q & ~hold & ~clr_low;
  wire logic [rstpc_pkg::PIN_W-1:0] pin_oe_d = float_q ? '0 : i_pin_drive_req;

  // The reset pin is high while clearing, driven low in hold and floated
  // only in the pin float test mode.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_reset_out <= 1'b1;
      o_reset_out_oe <= 1'b1;
    end else begin
      o_reset_out <= reset_drive;
      o_reset_out_oe <= ~float_q;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_muxed_addr_data_low_bits_oe <= 1'b0;
      o_pin_oe <= '0;
      o_oscillator_drive_pin_oe <= 1'b1;
    end else begin
      o_muxed_addr_data_low_bits_oe <= ad_oe_d;
      o_pin_oe <= pin_oe_d;
      o_oscillator_drive_pin_oe <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_pin_float_test_mode <= 1'b0;
      o_enhanced_mode <= 1'b0;
      o_fetch_start <= 1'b0;
    end else begin
      o_pin_float_test_mode <= float_q;
      o_enhanced_mode <= enhanced_q;
      o_fetch_start <= fetch_q;
    end
  end

endmodule : rstpc_ctrl

// [bench/rstpc_ctrl_properties.sv]
// Checker for the reset output and pin state control block.
// Bound to rstpc_ctrl and sees only the ports of that module.
`timescale 1ns/100ps
module rstpc_props (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_external_clear_input_n,
  input wire logic i_hold_ack,
  input wire logic o_reset_out,
  input wire logic o_reset_out_oe,
  input wire logic o_muxed_addr_data_low_bits_oe,
  input wire logic [rstpc_pkg::PIN_W-1:0] o_pin_oe,
  input wire logic o_oscillator_drive_pin_oe,
  input wire logic o_pin_float_test_mode,
  input wire logic o_fetch_start
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  a_osc_kept: assert property (o_oscillator_drive_pin_oe) else $error("osc off");
  a_float_pins_off: assert property (o_pin_float_test_mode |-> o_pin_oe == 0 &&
    !o_reset_out_oe && !o_muxed_addr_data_low_bits_oe) else $error("float driven");
  a_hold_ad_off: assert property (i_hold_ack [*5] |->
    !o_muxed_addr_data_low_bits_oe) else $error("hold ad on");
  a_clear_ad_rst: assert property ((!i_external_clear_input_n && !i_hold_ack) [*5] |->
    !o_muxed_addr_data_low_bits_oe && o_reset_out) else $error("clear state");
  a_hold_rst_low: assert property ((i_hold_ack && !o_pin_float_test_mode) [*5] |->
    !o_reset_out && o_reset_out_oe) else $error("hold rst");
  a_release_stays: assert property ($rose(i_external_clear_input_n) && o_reset_out |=>
    o_reset_out [*2]) else $error("rst early");
  a_release_falls: assert property ($rose(i_external_clear_input_n) ##1
    (i_external_clear_input_n && !i_hold_ack) [*8] |-> !o_reset_out) else $error("rst late");
  a_fetch_pulse: assert property (o_fetch_start |-> !o_reset_out ##1 !o_fetch_start)
    else $error("fetch");
endmodule : rstpc_props
bind rstpc_ctrl rstpc_props rstpc_props_inst (.*);

// [bench/rstpc_src.sv]
// Model of the external clear source and the busy strap.
// Clocked by the reference clock.
`timescale 1ns/100ps
module rstpc_src (
  input wire logic i_ref_clk,
  input wire logic i_rel,
  input wire logic i_loop,
  input wire logic i_reset_out,
  output logic o_clear_n,
  output logic o_busy
);
  always_ff @(posedge i_ref_clk) o_clear_n <= i_rel;
  assign o_busy = i_loop ? i_reset_out : 1'h1;
endmodule : rstpc_src

// [bench/tb_reset_out_and_pin_state_control.sv]
// Testbench for the reset output and pin state control block.
// Uses rstpc_src as the clear source and the bound checker.
`timescale 1ns/100ps
module tb_reset_out_and_pin_state_control;
  logic clk = 0, rst = 1, rel = 0, loop = 0, hold = 0, sel_n = 1;
  logic [15:0] req = 16'hA5C3;
  wire cn, busy, ro, roe, adoe, osc, fl, en, fs;
  wire [15:0] poe;
  int n_fail = 0, comparisons = 0, n;
  initial forever #2.5 clk = ~clk;
  rstpc_src rstpc_src_inst (.i_ref_clk(clk), .i_rel(rel), .i_loop(loop), .i_reset_out(ro),
    .o_clear_n(cn), .o_busy(busy));
  rstpc_ctrl rstpc_ctrl_inst (.i_ref_clk(clk), .i_reset(rst), .i_external_clear_input_n(cn),
    .i_wait_test_busy(busy), .i_upper_memory_select_n(sel_n), .i_lower_memory_select_n(sel_n),
    .i_hold_ack(hold), .i_pin_drive_req(req), .o_reset_out(ro), .o_reset_out_oe(roe),
    .o_muxed_addr_data_low_bits_oe(adoe), .o_pin_oe(poe), .o_oscillator_drive_pin_oe(osc),
    .o_pin_float_test_mode(fl), .o_enhanced_mode(en), .o_fetch_start(fs));
  task chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task end_sim;
    if (n_fail == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  task t_boot(input logic l);
    rel <= 0;
    loop <= l;
    repeat (8) @(posedge clk);
    chk({ro, adoe}, 16'h2);
    rel <= 1;
    n = 0;
    while (ro === 1'h1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk(n > 4 && n < 10, 16'h1);
    repeat (12) @(posedge clk);
    chk(en, l);
  endtask : t_boot
  task t_hold;
    hold <= 1;
    repeat (6) @(posedge clk);
    chk({ro, roe, adoe, osc}, 16'h5);
    chk(poe, req);
    hold <= 0;
    repeat (4) @(posedge clk);
  endtask : t_hold
  task t_float;
    sel_n <= 0;
    t_boot(0);
    sel_n <= 1;
    repeat (2) @(posedge clk);
    chk({fl, roe, adoe, osc}, 16'h9);
    chk(poe, 16'h0);
  endtask : t_float
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    t_boot(0);
    t_boot(1);
    t_hold();
    t_float();
    t_boot(0);
    chk(fl, 16'h0);
    end_sim();
  end
  initial begin
    repeat (2000) @(posedge clk);
    n_fail++;
    end_sim();
  end
endmodule : tb_reset_out_and_pin_state_control
